// ===== rsdg_runtime_regs.sv
// Behaviour
// - Index 1F reads floppy rate, precompensation, power down, soft reset.
// - Index 20 mirrors first UART FIFO control; bits 5:4 reserved.
// - Index 21 mirrors second UART FIFO control with the same layout.
// - A clear disable bit 7..3 leaves the function to its activate bit.
// - A set disable bit 7..3 disables that function whatever its activate.
// - Function disable register resets to 00.
// - Disable bit 0 forces floppy write protect over pin and force bit.
// - Protect is OR of selects gated by force, protect pin, bit 0.
// - Disable bits 2:1 are reserved and read zero.
// - Disable bit 3 turns the floppy core off.
// - Disable bit 4 turns the MIDI port off; clear has no effect.
// - Disable bit 5 turns the second UART off.
// - Disable bit 6 turns the first UART off.
// - Disable bit 7 governs the parallel port.
// - Pin config bit 0: one is input, zero is output.
// - Pin config bit 1: one inverts the pin value.
// - Pin config bit 7: one open drain, zero push-pull; 6:3 reserved.
// - Index 23 bit 2 routes its pin to joystick button one.
// - Index 24 bit 2 routes its pin to joystick button two.
// - Both pin config registers reset to 01.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rsdg_runtime_regs (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_b, // Standby power-on reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic floppy_rate_wr, // Floppy rate register written
    input wire logic [7:0] floppy_rate_wdata, // Floppy rate value
    input wire logic uart_a_fcr_wr, // First UART FIFO control written
    input wire logic [7:0] uart_a_fcr_wdata, // First UART FIFO value
    input wire logic uart_b_fcr_wr, // Second UART FIFO control written
    input wire logic [7:0] uart_b_fcr_wdata, // Second UART FIFO value
    input wire logic floppy_activate, // Floppy activate bit
    input wire logic midi_activate, // MIDI port activate bit
    input wire logic uart_b_activate, // Second UART activate bit
    input wire logic uart_a_activate, // First UART activate bit
    input wire logic parallel_activate, // Parallel port activate bit
    input wire logic force_write_protect, // Forced protect config bit
    input wire logic drive_select_a_n, // Drive select 0, active low
    input wire logic drive_select_b_n, // Drive select 1, active low
    input wire logic write_protect_n, // Drive protect pin, active low
    output logic floppy_wp_core_n, // Protect to floppy core, low
    output logic floppy_enable, // Floppy core enabled
    output logic midi_enable, // MIDI port enabled
    output logic uart_b_enable, // Second UART enabled
    output logic uart_a_enable, // First UART enabled
    output logic parallel_enable, // Parallel port enabled
    input wire logic [1:0] gpio_pin_i, // Pin levels
    output logic [1:0] gpio_pin_o, // Pin output levels
    output logic [1:0] gpio_pin_oe, // Pin output enables
    input wire logic [1:0] gpio_drive_val, // Values to drive
    output logic [1:0] gpio_read_val, // Pin values as plain input
    output logic joy1_button_a, // Joystick 1 button 1
    output logic joy1_button_b // Joystick 1 button 2
);

    typedef struct packed {
        rsdg_pkg::rsdg_bus_e bus_st;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] func_dis;
        logic [7:0] cfg_b1;
        logic [7:0] cfg_b2;
        logic [4:0] enables;
        logic wp_core_n;
    } rsdg_top_s;

    rsdg_top_s state_q;
    rsdg_top_s state_d;
    logic [7:0] sh_rate;
    logic [7:0] sh_uart_a;
    logic [7:0] sh_uart_b;
    logic [5:0] idx;
    logic take;
    logic wr_lane;
    logic [7:0] rd_val;
    logic protect;

    // Shadows of write-only sources
    rsdg_shadow #(
        .RST_VAL(rsdg_pkg::SHADOW_RST),
        .MASK(rsdg_pkg::FLOPPY_RATE_MASK)
    ) u_rate_shadow (
        .clk(clk),
        .rst_b(rst_b),
        .load(floppy_rate_wr),
        .value(floppy_rate_wdata),
        .shadow(sh_rate)
    );

    rsdg_shadow #(
        .RST_VAL(rsdg_pkg::SHADOW_RST),
        .MASK(rsdg_pkg::FCR_MASK)
    ) u_uart_a_shadow (
        .clk(clk),
        .rst_b(rst_b),
        .load(uart_a_fcr_wr),
        .value(uart_a_fcr_wdata),
        .shadow(sh_uart_a)
    );

    rsdg_shadow #(
        .RST_VAL(rsdg_pkg::SHADOW_RST),
        .MASK(rsdg_pkg::FCR_MASK)
    ) u_uart_b_shadow (
        .clk(clk),
        .rst_b(rst_b),
        .load(uart_b_fcr_wr),
        .value(uart_b_fcr_wdata),
        .shadow(sh_uart_b)
    );

    // Pad cells driven by the two config registers
    rsdg_pin_cell u_pin_b1 (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(state_q.cfg_b1),
        .drive_val(gpio_drive_val[0]),
        .pin_i(gpio_pin_i[0]),
        .pin_o(gpio_pin_o[0]),
        .pin_oe(gpio_pin_oe[0]),
        .read_val(gpio_read_val[0]),
        .alt_val(joy1_button_a)
    );

    rsdg_pin_cell u_pin_b2 (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(state_q.cfg_b2),
        .drive_val(gpio_drive_val[1]),
        .pin_i(gpio_pin_i[1]),
        .pin_o(gpio_pin_o[1]),
        .pin_oe(gpio_pin_oe[1]),
        .read_val(gpio_read_val[1]),
        .alt_val(joy1_button_b)
    );

    // Bus decode; only the low byte lane carries register data
    assign idx = wb_adr_i[7:2];
    assign take = (state_q.bus_st == rsdg_pkg::RSDG_IDLE)
        && wb_cyc_i && wb_stb_i;
    assign wr_lane = wb_we_i && wb_sel_i[0];

    // Read mux; unmapped indices answer zero rather than error
    always_comb begin
        case (idx)
            rsdg_pkg::IDX_FLOPPY_RATE: rd_val = sh_rate;
            rsdg_pkg::IDX_UART_A_FCR: rd_val = sh_uart_a;
            rsdg_pkg::IDX_UART_B_FCR: rd_val = sh_uart_b;
            rsdg_pkg::IDX_FUNC_DIS: rd_val = state_q.func_dis;
            rsdg_pkg::IDX_JOY_B1_CFG: rd_val = state_q.cfg_b1;
            rsdg_pkg::IDX_JOY_B2_CFG: rd_val = state_q.cfg_b2;
            default: rd_val = 8'h00;
        endcase
    end

    // Write protect to the core, asserted-high terms ORed
    assign protect = (!drive_select_a_n && force_write_protect)
        || (!drive_select_b_n && force_write_protect)
        || !write_protect_n
        || state_q.func_dis[rsdg_pkg::DIS_WP];

    // Next state: bus slave, register writes, function gating
    always_comb begin
        state_d = state_q;
        state_d.ack = 1'b0;
        case (state_q.bus_st)
            rsdg_pkg::RSDG_IDLE: begin
                if (take) begin
                    state_d.bus_st = rsdg_pkg::RSDG_ACK;
                    state_d.ack = 1'b1;
                    state_d.rdata = wb_we_i ? 8'h00 : rd_val;
                    if (wr_lane) begin
                        // Shadow indices are read-only; writes fall away
                        case (idx)
                            rsdg_pkg::IDX_FUNC_DIS: begin
                                state_d.func_dis = wb_dat_i[7:0]
                                    & rsdg_pkg::FUNC_DIS_MASK;
                            end
                            rsdg_pkg::IDX_JOY_B1_CFG: begin
                                state_d.cfg_b1 = wb_dat_i[7:0]
                                    & rsdg_pkg::PIN_CFG_MASK;
                            end
                            rsdg_pkg::IDX_JOY_B2_CFG: begin
                                state_d.cfg_b2 = wb_dat_i[7:0]
                                    & rsdg_pkg::PIN_CFG_MASK;
                            end
                            default: begin
                                state_d.func_dis = state_q.func_dis;
                            end
                        endcase
                    end
                end
            end
            rsdg_pkg::RSDG_ACK: begin
                // One idle cycle between answers avoids double takes
                state_d.bus_st = rsdg_pkg::RSDG_IDLE;
            end
            default: begin
                state_d.bus_st = rsdg_pkg::RSDG_IDLE;
            end
        endcase
        // Disable bits override activate bits; clear means pass
        state_d.enables[0] = floppy_activate
            && !state_q.func_dis[rsdg_pkg::DIS_FLOPPY];
        state_d.enables[1] = midi_activate
            && !state_q.func_dis[rsdg_pkg::DIS_MIDI];
        state_d.enables[2] = uart_b_activate
            && !state_q.func_dis[rsdg_pkg::DIS_UART_B];
        state_d.enables[3] = uart_a_activate
            && !state_q.func_dis[rsdg_pkg::DIS_UART_A];
        state_d.enables[4] = parallel_activate
            && !state_q.func_dis[rsdg_pkg::DIS_PAR];
        state_d.wp_core_n = !protect;
    end

    // State register, defaults on standby power-on reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q.bus_st <= rsdg_pkg::RSDG_IDLE;
            state_q.ack <= 1'b0;
            state_q.rdata <= 8'h00;
            state_q.func_dis <= rsdg_pkg::FUNC_DIS_RST;
            state_q.cfg_b1 <= rsdg_pkg::PIN_CFG_RST;
            state_q.cfg_b2 <= rsdg_pkg::PIN_CFG_RST;
            state_q.enables <= 5'h00;
            state_q.wp_core_n <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = {24'h000000, state_q.rdata};
    assign floppy_enable = state_q.enables[0];
    assign midi_enable = state_q.enables[1];
    assign uart_b_enable = state_q.enables[2];
    assign uart_a_enable = state_q.enables[3];
    assign parallel_enable = state_q.enables[4];
    assign floppy_wp_core_n = state_q.wp_core_n;

    // Checks
    property p_rate_shadow;
        @(posedge clk) disable iff (!rst_b)
        floppy_rate_wr |=> sh_rate == ($past(floppy_rate_wdata)
            & rsdg_pkg::FLOPPY_RATE_MASK);
    endproperty
    a_rate_shadow: assert property (p_rate_shadow)
        else $error("floppy rate shadow missed its write");

    property p_uart_a_shadow;
        @(posedge clk) disable iff (!rst_b)
        uart_a_fcr_wr |=> sh_uart_a[7:6] == $past(uart_a_fcr_wdata[7:6])
            && sh_uart_a[5:4] == 2'h0;
    endproperty
    a_uart_a_shadow: assert property (p_uart_a_shadow)
        else $error("first uart shadow wrong");

    property p_uart_b_shadow;
        @(posedge clk) disable iff (!rst_b)
        uart_b_fcr_wr ##1 !uart_b_fcr_wr |=> sh_uart_b
            == ($past(uart_b_fcr_wdata, 2) & rsdg_pkg::FCR_MASK);
    endproperty
    a_uart_b_shadow: assert property (p_uart_b_shadow)
        else $error("second uart shadow not held");

    property p_dis_pass;
        @(posedge clk) disable iff (!rst_b)
        rst_b && !state_q.func_dis[rsdg_pkg::DIS_FLOPPY]
            |=> floppy_enable == $past(floppy_activate);
    endproperty
    a_dis_pass: assert property (p_dis_pass)
        else $error("floppy enable ignores activate bit");

    property p_dis_force;
        @(posedge clk) disable iff (!rst_b)
        state_q.func_dis[rsdg_pkg::DIS_UART_A]
            && state_q.func_dis[rsdg_pkg::DIS_PAR]
            |=> !uart_a_enable && !parallel_enable;
    endproperty
    a_dis_force: assert property (p_dis_force)
        else $error("disabled function still enabled");

    property p_midi_off;
        @(posedge clk) disable iff (!rst_b)
        state_q.func_dis[rsdg_pkg::DIS_MIDI]
            && state_q.func_dis[rsdg_pkg::DIS_UART_B]
            |=> !midi_enable && !uart_b_enable;
    endproperty
    a_midi_off: assert property (p_midi_off)
        else $error("midi or second uart not disabled");

    property p_reset_vals;
        @(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> state_q.func_dis == rsdg_pkg::FUNC_DIS_RST
            && state_q.cfg_b1 == rsdg_pkg::PIN_CFG_RST
            && state_q.cfg_b2 == rsdg_pkg::PIN_CFG_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("register default wrong after reset");

    property p_wp_force;
        @(posedge clk) disable iff (!rst_b)
        state_q.func_dis[rsdg_pkg::DIS_WP] |=> !floppy_wp_core_n;
    endproperty
    a_wp_force: assert property (p_wp_force)
        else $error("disable bit 0 did not protect");

    property p_wp_or;
        @(posedge clk) disable iff (!rst_b)
        write_protect_n && !force_write_protect
            && !state_q.func_dis[rsdg_pkg::DIS_WP] |=> floppy_wp_core_n;
    endproperty
    a_wp_or: assert property (p_wp_or)
        else $error("protect asserted with no cause");

    property p_rsvd_zero;
        @(posedge clk) disable iff (!rst_b)
        state_q.func_dis[2:1] == 2'h0 && state_q.cfg_b1[6:3] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits not zero");

    property p_pin_input;
        @(posedge clk) disable iff (!rst_b)
        state_q.cfg_b1[rsdg_pkg::CFG_DIR] |=> !gpio_pin_oe[0];
    endproperty
    a_pin_input: assert property (p_pin_input)
        else $error("input pin is driven");

    property p_pin_pol;
        @(posedge clk) disable iff (!rst_b)
        !state_q.cfg_b2[rsdg_pkg::CFG_ALT] |=> gpio_read_val[1]
            == ($past(gpio_pin_i[1]) ^ $past(state_q.cfg_b2[1]));
    endproperty
    a_pin_pol: assert property (p_pin_pol)
        else $error("pin polarity not applied");

    property p_joy_route;
        @(posedge clk) disable iff (!rst_b)
        state_q.cfg_b1[rsdg_pkg::CFG_ALT] |=> joy1_button_a
            == ($past(gpio_pin_i[0]) ^ $past(state_q.cfg_b1[1]));
    endproperty
    a_joy_route: assert property (p_joy_route)
        else $error("joystick button 1 not routed");

    property p_joy_off;
        @(posedge clk) disable iff (!rst_b)
        !state_q.cfg_b2[rsdg_pkg::CFG_ALT] |=> !joy1_button_b;
    endproperty
    a_joy_off: assert property (p_joy_off)
        else $error("joystick button 2 routed in gpio mode");

    property p_ack_pulse;
        @(posedge clk) disable iff (!rst_b)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack is not a one cycle answer");

    c_dis_write: cover property (@(posedge clk) disable iff (!rst_b)
        take && wr_lane && idx == rsdg_pkg::IDX_FUNC_DIS);
    c_shadow_read: cover property (@(posedge clk) disable iff (!rst_b)
        take && !wb_we_i && idx == rsdg_pkg::IDX_FLOPPY_RATE);
    c_joy_alt: cover property (@(posedge clk) disable iff (!rst_b)
        state_q.cfg_b1[rsdg_pkg::CFG_ALT] ##1 joy1_button_a);
    c_open_drain: cover property (@(posedge clk) disable iff (!rst_b)
        state_q.cfg_b2[rsdg_pkg::CFG_OD] && gpio_pin_oe[1]);

endmodule

`default_nettype wire

// ===== rsdg_pkg.sv
package rsdg_pkg;

    // Bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_FLOPPY_RATE = 6'h1F;
    localparam logic [5:0] IDX_UART_A_FCR = 6'h20;
    localparam logic [5:0] IDX_UART_B_FCR = 6'h21;
    localparam logic [5:0] IDX_FUNC_DIS = 6'h22;
    localparam logic [5:0] IDX_JOY_B1_CFG = 6'h23;
    localparam logic [5:0] IDX_JOY_B2_CFG = 6'h24;

    // Reset values
    localparam logic [7:0] SHADOW_RST = 8'h00;
    localparam logic [7:0] FUNC_DIS_RST = 8'h00;
    localparam logic [7:0] PIN_CFG_RST = 8'h01;

    // Implemented bits; reserved positions read as zero
    localparam logic [7:0] FLOPPY_RATE_MASK = 8'hDF;
    localparam logic [7:0] FCR_MASK = 8'hCF;
    localparam logic [7:0] FUNC_DIS_MASK = 8'hF9;
    localparam logic [7:0] PIN_CFG_MASK = 8'h87;

    // Function disable fields
    localparam int DIS_WP = 0;
    localparam int DIS_FLOPPY = 3;
    localparam int DIS_MIDI = 4;
    localparam int DIS_UART_B = 5;
    localparam int DIS_UART_A = 6;
    localparam int DIS_PAR = 7;

    // Pin configuration fields
    localparam int CFG_DIR = 0;
    localparam int CFG_POL = 1;
    localparam int CFG_ALT = 2;
    localparam int CFG_OD = 7;

    // Bus slave states
    typedef enum logic [0:0] {
        RSDG_IDLE = 1'b0,
        RSDG_ACK = 1'b1
    } rsdg_bus_e;

endpackage

// ===== rsdg_shadow.sv
`timescale 1ns/1ps
`default_nettype none

module rsdg_shadow #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic load, // Source register written
    input wire logic [7:0] value, // Value written to source
    output logic [7:0] shadow // Copy for read-back
);

    typedef struct packed {
        logic [7:0] val;
    } rsdg_shadow_s;

    rsdg_shadow_s state_q;
    rsdg_shadow_s state_d;

    // Capture last written value, reserved bits dropped
    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d.val = value & MASK;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{val: RST_VAL};
        end else begin
            state_q <= state_d;
        end
    end

    assign shadow = state_q.val;

endmodule

`default_nettype wire

// ===== rsdg_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module rsdg_pin_cell (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [7:0] cfg, // Pin configuration register
    input wire logic drive_val, // Value to drive in output mode
    input wire logic pin_i, // Pin level
    output logic pin_o, // Pin output level
    output logic pin_oe, // Pin output enable, high drives
    output logic read_val, // Pin value seen as plain input
    output logic alt_val // Pin value routed to joystick
);

    typedef struct packed {
        logic pin_o;
        logic pin_oe;
        logic read_val;
        logic alt_val;
    } rsdg_pin_s;

    rsdg_pin_s state_q;
    rsdg_pin_s state_d;
    logic lvl;
    logic drive;

    // Pad logic; alternate function keeps the pad an input
    always_comb begin
        state_d = state_q;
        lvl = drive_val ^ cfg[rsdg_pkg::CFG_POL];
        drive = !cfg[rsdg_pkg::CFG_DIR] && !cfg[rsdg_pkg::CFG_ALT];
        state_d.pin_o = cfg[rsdg_pkg::CFG_OD] ? 1'b0 : lvl;
        state_d.pin_oe = drive && (cfg[rsdg_pkg::CFG_OD] ? !lvl : 1'b1);
        state_d.read_val = !cfg[rsdg_pkg::CFG_ALT]
            && (pin_i ^ cfg[rsdg_pkg::CFG_POL]);
        state_d.alt_val = cfg[rsdg_pkg::CFG_ALT]
            && (pin_i ^ cfg[rsdg_pkg::CFG_POL]);
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_o = state_q.pin_o;
    assign pin_oe = state_q.pin_oe;
    assign read_val = state_q.read_val;
    assign alt_val = state_q.alt_val;

endmodule

`default_nettype wire

// ===== rsdg_runtime_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module rsdg_runtime_regs_bench;
    logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seen;
    logic floppy_rate_wr, uart_a_fcr_wr, uart_b_fcr_wr;
    logic [7:0] floppy_rate_wdata, uart_a_fcr_wdata, uart_b_fcr_wdata;
    logic floppy_activate, midi_activate, uart_b_activate;
    logic uart_a_activate, parallel_activate, force_write_protect;
    logic drive_select_a_n, drive_select_b_n, write_protect_n;
    logic floppy_wp_core_n, floppy_enable, midi_enable, uart_b_enable;
    logic uart_a_enable, parallel_enable, joy1_button_a, joy1_button_b;
    logic [1:0] gpio_pin_i, gpio_pin_o, gpio_pin_oe, gpio_drive_val;
    logic [1:0] gpio_read_val;
    logic [4:0] v;
    logic [3:0] lanes;
    logic [15:0] t;
    logic [15:0] tbl [8];
    int error_cnt, check_count;

    rsdg_runtime_regs uut (
        .clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .floppy_rate_wr, .floppy_rate_wdata,
        .uart_a_fcr_wr, .uart_a_fcr_wdata, .uart_b_fcr_wr, .uart_b_fcr_wdata,
        .floppy_activate, .midi_activate, .uart_b_activate, .uart_a_activate,
        .parallel_activate, .force_write_protect, .drive_select_a_n,
        .drive_select_b_n, .write_protect_n, .floppy_wp_core_n,
        .floppy_enable, .midi_enable, .uart_b_enable, .uart_a_enable,
        .parallel_enable, .gpio_pin_i, .gpio_pin_o, .gpio_pin_oe,
        .gpio_drive_val, .gpio_read_val, .joy1_button_a, .joy1_button_b
    );

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Classic cycle; data taken only at the edge that sees ack
    task automatic wb_req(input logic w, input logic [5:0] idx,
                          input logic [7:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= lanes;
        wb_dat_i <= {24'h000000, d};
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        seen = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [5:0] idx,
                          input logic [7:0] exp);
        wb_req(1'b0, idx, 8'h00);
        chk(name, {24'h000000, exp}, seen);
    endtask

    // Registered outputs need one edge; two gives margin
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles of the tests
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        // Pin cases: cfg, drive, pin level, then oe, o, read, joystick
        tbl = '{16'h002C, 16'h0238, 16'h8032, 16'h8008,
                16'h0302, 16'h0511, 16'h0701, 16'h0112};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
        wb_dat_i = '0;
        {floppy_rate_wr, uart_a_fcr_wr, uart_b_fcr_wr} = '0;
        {floppy_rate_wdata, uart_a_fcr_wdata, uart_b_fcr_wdata} = '0;
        {parallel_activate, uart_a_activate, uart_b_activate} = 3'h7;
        {midi_activate, floppy_activate, force_write_protect} = 3'h6;
        {drive_select_a_n, drive_select_b_n, write_protect_n} = 3'h7;
        {gpio_pin_i, gpio_drive_val} = '0;
        error_cnt = 0;
        check_count = 0;
        lanes = 4'hF;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, unmapped place
        rd_chk("rate", rsdg_pkg::IDX_FLOPPY_RATE, 8'h00);
        rd_chk("dis", rsdg_pkg::IDX_FUNC_DIS, 8'h00);
        rd_chk("cfg1", rsdg_pkg::IDX_JOY_B1_CFG, 8'h01);
        rd_chk("cfg2", rsdg_pkg::IDX_JOY_B2_CFG, 8'h01);
        rd_chk("unmapped", 6'h3F, 8'h00);
        // Shadows capture their sources; bus writes leave them alone
        @(posedge clk);
        {floppy_rate_wr, uart_a_fcr_wr, uart_b_fcr_wr} <= 3'h7;
        floppy_rate_wdata <= 8'hFF;
        uart_a_fcr_wdata <= 8'hFF;
        uart_b_fcr_wdata <= 8'hA5;
        @(posedge clk);
        floppy_rate_wdata <= 8'h7A;
        {uart_a_fcr_wr, uart_b_fcr_wr} <= 2'h0;
        @(posedge clk);
        floppy_rate_wr <= 1'b0;
        wb_req(1'b1, rsdg_pkg::IDX_UART_A_FCR, 8'h00);
        rd_chk("rate", rsdg_pkg::IDX_FLOPPY_RATE, 8'h5A);
        rd_chk("fcr_a", rsdg_pkg::IDX_UART_A_FCR, 8'hCF);
        rd_chk("fcr_b", rsdg_pkg::IDX_UART_B_FCR, 8'h85);
        // Reserved disable bits read zero
        wb_req(1'b1, rsdg_pkg::IDX_FUNC_DIS, 8'hFF);
        rd_chk("dis", rsdg_pkg::IDX_FUNC_DIS, 8'hF9);
        // Each disable bit 7..3 alone, all activates high
        for (int b = 0; b < 5; b++) begin
            wb_req(1'b1, rsdg_pkg::IDX_FUNC_DIS, 8'h08 << b);
            settle();
            chk("enables", {27'h0, ~(5'h01 << b)}, {parallel_enable,
                uart_a_enable, uart_b_enable, midi_enable,
                floppy_enable});
        end
        // Clear disables leave activates in charge
        wb_req(1'b1, rsdg_pkg::IDX_FUNC_DIS, 8'h00);
        @(posedge clk);
        {parallel_activate, uart_a_activate, uart_b_activate} <= 3'h5;
        {midi_activate, floppy_activate} <= 2'h1;
        settle();
        chk("enables", 32'h15, {parallel_enable, uart_a_enable,
            uart_b_enable, midi_enable, floppy_enable});
        // A write without the low lane is acked and dropped
        lanes = 4'hE;
        wb_req(1'b1, rsdg_pkg::IDX_FUNC_DIS, 8'hFF);
        lanes = 4'hF;
        rd_chk("dis_lane", rsdg_pkg::IDX_FUNC_DIS, 8'h00);
        // Every protect term combination
        for (int i = 0; i < 32; i++) begin
            v = 5'(i);
            wb_req(1'b1, rsdg_pkg::IDX_FUNC_DIS, {7'h00, v[4]});
            @(posedge clk);
            {force_write_protect, drive_select_a_n} <= v[3:2];
            {drive_select_b_n, write_protect_n} <= v[1:0];
            settle();
            chk("wp_n", 32'(!((!v[2] && v[3]) || (!v[1] && v[3]) ||
                !v[0] || v[4])), 32'(floppy_wp_core_n));
        end
        // Pin config readback masks reserved bits
        wb_req(1'b1, rsdg_pkg::IDX_JOY_B2_CFG, 8'hFF);
        rd_chk("cfg2", rsdg_pkg::IDX_JOY_B2_CFG, 8'h87);
        // Direction, polarity, driver type, joystick routing
        for (int n = 0; n < 8; n++) begin
            t = tbl[n];
            wb_req(1'b1, rsdg_pkg::IDX_JOY_B1_CFG, t[15:8]);
            wb_req(1'b1, rsdg_pkg::IDX_JOY_B2_CFG, t[15:8]);
            @(posedge clk);
            gpio_drive_val <= {2{t[5]}};
            gpio_pin_i <= {2{t[4]}};
            settle();
            chk("pin0", 32'(t[3:0]), {gpio_pin_oe[0], gpio_pin_o[0] &
                gpio_pin_oe[0], gpio_read_val[0],
                joy1_button_a});
            chk("pin1", 32'(t[3:0]), {gpio_pin_oe[1], gpio_pin_o[1] &
                gpio_pin_oe[1], gpio_read_val[1],
                joy1_button_b});
        end
        wrap_up();
    end
endmodule

`default_nettype wire
